// >>> tb.sv
// Self-checking testbench for the flag and event register block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import uifr_pkg::*;
    logic clk, nrst, reg_wr, reg_rd, pkt_start, rx_active, rx_error, crc16_fail;
    logic token_ok, pid_valid, sof_seen, susp_cmd, suspended, resume_out, seen_res;
    logic port_a, port_b, port_c, pd_lo, pd_hi;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, otg_out, wv;
    logic [3:0] pid_in, token_ep;
    logic [1:0] line_state, ls_cmd, ls_filt;
    logic [6:0] flags;
    logic [4:0] rx_ep;
    logic [2:0] conf;
    logic [8:0] pwr_out;
    logic [7:0] addr_t [7];
    logic [31:0] mask_t [7];
    int n_fail = 0;
    int check_count = 0;
    uifr_phy_model u_phy (.clk(clk), .ls_cmd(ls_cmd), .susp_cmd(susp_cmd),
        .line_state(line_state), .suspended(suspended));
    uifr_regs u_dut (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .pkt_start(pkt_start), .rx_active(rx_active), .rx_error(rx_error),
        .crc16_fail(crc16_fail), .token_ok(token_ok), .pid_valid(pid_valid), .pid_in(pid_in),
        .token_ep(token_ep), .sof_seen(sof_seen), .line_state(line_state),
        .suspended(suspended), .signal_flag_vector(flags), .flag_out_port_a(port_a),
        .flag_out_port_b(port_b), .flag_out_port_c(port_c), .rx_ep_out(rx_ep),
        .ls_filtered(ls_filt), .line_port_low_pd_en(pd_lo), .line_port_high_pd_en(pd_hi),
        .phy_config_pins(conf), .resume_out(resume_out), .otg_flag_mask_out(otg_out),
        .power_signal_out(pwr_out));
    ////////////////////////////////////////////////////////////////////////////
    // Free-running clock at 125 MHz.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Counts a comparison and reports a difference at once.
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        #1 chk($sformatf("reg_%h", a), reg_rdata, exp);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Cuts a hang short well past the expected run length.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence of register calls and port checks.
    initial begin
        {nrst, reg_wr, reg_rd, pkt_start, rx_active, rx_error, crc16_fail} = 7'h0;
        {token_ok, pid_valid, sof_seen, susp_cmd} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        pid_in = 4'h0;
        token_ep = 4'h0;
        ls_cmd = LS_J;
        addr_t = '{OFS_STICKY, OFS_PORT_MASKS, OFS_SOF, OFS_EP_MATCH, OFS_OTG_MASK, OFS_POWER,
            OFS_PHY_CTRL};
        mask_t = '{STICKY_WMASK, PORTS_WMASK, SOF_WMASK, EPM_WMASK, 32'hFFFF_FFFF, PWR_WMASK,
            PHY_WMASK};
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        wt(2);
        chk("pd_en", {pd_lo, pd_hi}, 2'h3);
        for (int i = 0; i < 7; i++) rdchk(addr_t[i], 32'h0);
        rdchk(OFS_PID, 32'h0);
        rdchk(OFS_ENDPOINT, 32'h0);
        wr(OFS_PID, 32'hFFFF_FFFF);
        wr(8'h44, 32'hFFFF_FFFF);
        rdchk(OFS_PID, 32'h0);
        rdchk(8'h44, 32'h0);
        for (int i = 0; i < 7; i++) begin
            wv = (i == 6) ? 32'hFFFF_C0FF : 32'hFFFF_FFFF;
            wr(addr_t[i], wv);
            rdchk(addr_t[i], wv & mask_t[i]);
        end
        chk("pd_en", {pd_lo, pd_hi}, 2'h0);
        chk("conf", conf, 3'h7);
        chk("otg", otg_out, 32'hFFFF_FFFF);
        chk("pwr", pwr_out, 32'h1FF);
        wr(OFS_RESET, 32'h0);
        for (int i = 0; i < 7; i++) rdchk(addr_t[i], (i == 6) ? 32'h0004_00F0 : 32'h0);
        chk("otg_pwr", otg_out | pwr_out, 32'h0);
        wr(OFS_PHY_CTRL, 32'h0);
        // Live tracking, latching and stickiness seen through the three ports.
        wr(OFS_PORT_MASKS, 32'h0040_0201);
        @(posedge clk);
        rx_active <= 1'b1;
        rx_error <= 1'b1;
        wt(6);
        chk("port_b", port_b, 1'b1);
        chk("port_a", port_a, 1'b1);
        chk("port_c", port_c, 1'b0);
        chk("flags", flags, 7'h0B);
        @(posedge clk);
        rx_active <= 1'b0;
        rx_error <= 1'b0;
        wt(6);
        chk("port_b", port_b, 1'b0);
        wr(OFS_STICKY, 32'h2);
        @(posedge clk);
        rx_active <= 1'b1;
        wt(6);
        @(posedge clk);
        rx_active <= 1'b0;
        wt(6);
        chk("port_b", port_b, 1'b1);
        wr(OFS_STICKY, 32'h2);
        wt(3);
        chk("port_b", port_b, 1'b0);
        // Token captures and endpoint marking, marked then unmarked.
        wr(OFS_EP_MATCH, 32'h0000_0020);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            token_ok <= 1'b1;
            pid_valid <= 1'b1;
            pid_in <= (k == 0) ? 4'hD : 4'h9;
            token_ep <= (k == 0) ? 4'h5 : 4'h3;
            @(posedge clk);
            token_ok <= 1'b0;
            pid_valid <= 1'b0;
            wt(4);
            chk("port_c", port_c, 1'b1);
            chk("rx_ep", rx_ep, (k == 0) ? 5'h15 : 5'h03);
            rdchk(OFS_PID, (k == 0) ? 32'hD : 32'h9);
            rdchk(OFS_ENDPOINT, (k == 0) ? 32'h15 : 32'h13);
        end
        chk("port_a", port_a, 1'b1);
        @(posedge clk);
        pkt_start <= 1'b1;
        @(posedge clk);
        pkt_start <= 1'b0;
        wt(4);
        chk("port_c", port_c, 1'b0);
        chk("port_a", port_a, 1'b0);
        // Frame counter wraps at eleven bits.
        wr(OFS_SOF, 32'h7FF);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            sof_seen <= 1'b1;
            @(posedge clk);
            sof_seen <= 1'b0;
            rdchk(OFS_SOF, k);
        end
        // Line filter of eight clocks, checked on ls_filtered.
        wr(OFS_PHY_CTRL, 32'h330);
        wt(40);
        chk("conf", conf, 3'h3);
        chk("ls_filt", ls_filt, LS_J);
        ls_cmd <= LS_K;
        wt(6);
        chk("ls_filt", ls_filt, LS_J);
        wt(20);
        chk("ls_filt", ls_filt, LS_K);
        // Auto-resume by K and by SE0, each cleared by a zero write.
        wr(OFS_PHY_CTRL, 32'h380);
        for (int k = 0; k < 2; k++) begin
            ls_cmd <= LS_J;
            wt(40);
            susp_cmd <= 1'b1;
            wt(10);
            ls_cmd <= (k == 0) ? LS_K : LS_SE0;
            seen_res = 1'b0;
            repeat (60) begin
                @(posedge clk);
                #1 if (resume_out === 1'b1) seen_res = 1'b1;
            end
            chk("resume_out", seen_res, 1'b1);
            rdchk(OFS_PHY_CTRL, (k == 0) ? 32'h1380 : 32'h2380);
            susp_cmd <= 1'b0;
            wr(OFS_PHY_CTRL, 32'h380);
            rdchk(OFS_PHY_CTRL, 32'h380);
        end
        end_of_test();
    end
endmodule
`default_nettype wire

// >>> uifr_ls_filter.sv
// Line-state filter that holds off each change for a power-of-two number of clocks.
`timescale 1ns/1ps
`default_nettype none
module uifr_ls_filter
    import uifr_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic soft_rst,
    input wire logic [3:0] log2_delay,
    input wire logic [1:0] ls_in,
    output logic [1:0] ls_out
);
    logic [FILT_CNT_W-1:0] cnt_ff;
    logic [1:0] cand_ff;
    logic [FILT_CNT_W:0] target;

    // Number of cycles a new level must persist before it is passed on.
    assign target = (FILT_CNT_W+1)'(1) << log2_delay;

    // A change restarts the count; the output only takes it after the full wait.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= '0;
            cand_ff <= LS_SE0;
            ls_out <= LS_SE0;
        end else if (soft_rst) begin
            cnt_ff <= '0;
            cand_ff <= LS_SE0;
            ls_out <= LS_SE0;
        end else if (ls_in != cand_ff) begin
            cand_ff <= ls_in;
            cnt_ff <= '0;
        end else if (ls_in != ls_out) begin
            if ({1'b0, cnt_ff} + (FILT_CNT_W+1)'(1) >= target) begin
                ls_out <= cand_ff;
                cnt_ff <= '0;
            end else begin
                cnt_ff <= cnt_ff + FILT_CNT_W'(1);
            end
        end
    end
endmodule
`default_nettype wire

// >>> uifr_phy_model.sv
// Behavioural model of the PHY line-state and suspend signals.
`timescale 1ns/1ps
`default_nettype none
module uifr_phy_model (
    input wire logic clk,
    input wire logic [1:0] ls_cmd,
    input wire logic susp_cmd,
    output logic [1:0] line_state,
    output logic suspended
);
    // The line moves just after a clock edge, as a PHY output would.
    always_ff @(posedge clk) begin
        line_state <= ls_cmd;
        suspended <= susp_cmd;
    end
endmodule
`default_nettype wire

// >>> uifr_pkg.sv
// Package with register offsets, field positions and reset values of the flag and event registers.
package uifr_pkg;
    localparam logic [7:0] OFS_RESET = 8'h00;
    localparam logic [7:0] OFS_STICKY = 8'h20;
    localparam logic [7:0] OFS_PORT_MASKS = 8'h24;
    localparam logic [7:0] OFS_SOF = 8'h28;
    localparam logic [7:0] OFS_PID = 8'h2C;
    localparam logic [7:0] OFS_ENDPOINT = 8'h30;
    localparam logic [7:0] OFS_EP_MATCH = 8'h34;
    localparam logic [7:0] OFS_OTG_MASK = 8'h38;
    localparam logic [7:0] OFS_POWER = 8'h3C;
    localparam logic [7:0] OFS_PHY_CTRL = 8'h40;
    localparam int NUM_FLAGS = 7;
    localparam int FLAG_TOKEN_OK = 6;
    localparam int FLAG_SE0 = 5;
    localparam int FLAG_K = 4;
    localparam int FLAG_J = 3;
    localparam int FLAG_CRC16 = 2;
    localparam int FLAG_RXACTIVE = 1;
    localparam int FLAG_RXERROR = 0;
    localparam int PORT_A_LSB = 0;
    localparam int PORT_B_LSB = 8;
    localparam int PORT_C_LSB = 16;
    localparam int EP_VALID_BIT = 4;
    localparam int PWR_VALID_BIT = 8;
    localparam int PHY_PD_DIS_BIT = 18;
    localparam int PHY_SE0_RES_BIT = 13;
    localparam int PHY_K_RES_BIT = 12;
    localparam int PHY_FILT_MSB = 11;
    localparam int PHY_FILT_LSB = 8;
    localparam int PHY_SUSP_BIT = 7;
    localparam int PHY_CONF_MSB = 6;
    localparam int PHY_CONF_LSB = 4;
    localparam logic [31:0] RST_ZERO = 32'h0;
    localparam logic [31:0] STICKY_WMASK = 32'h0000_007F;
    localparam logic [31:0] PORTS_WMASK = 32'h00FF_FFFF;
    localparam logic [31:0] SOF_WMASK = 32'h0000_07FF;
    localparam logic [31:0] EPM_WMASK = 32'h0000_FFFF;
    localparam logic [31:0] PWR_WMASK = 32'h0000_01FF;
    localparam logic [31:0] PHY_WMASK = 32'h0004_3FF0;
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_J = 2'h1;
    localparam logic [1:0] LS_K = 2'h2;
    localparam int FILT_CNT_W = 16;
endpackage

// >>> uifr_regs.sv
// Upper register set of the USB interface manager: flags, masks, captures and PHY control.
//
// Behaviour
// - Seven-bit stickiness mask, one per flag.
// - Sticky flag holds until one written.
// - Non-sticky flags 1, 3, 4, 5 follow their source signal.
// - Three eight-bit masks OR flags onto ports.
// - Eleven-bit frame counter, readable, writable, reset zero.
// - Capture last received packet identifier.
// - Capture endpoint of last received token.
// - Endpoint valid bit reads one when valid.
// - Marked endpoints delivered ORed with 0x10.
// - Bit 18 disables data line pulldowns.
// - SE0 auto-resume sets bit 13; write zero clears.
// - K auto-resume sets bit 12; write zero clears.
// - Line-state change delayed two-power-field clocks.
// - Bit 7 lets suspend controller handle resume.
// - Bits 6:4 drive the PHY config pins.
// - Write to reset register clears manager state.
// - Non-sticky flags clear on next packet.
// - Flag 6 set on successful token decode.
`timescale 1ns/1ps
`default_nettype none
module uifr_regs
    import uifr_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    // Register access.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // Packet events and PHY status.
    input wire logic pkt_start,
    input wire logic rx_active,
    input wire logic rx_error,
    input wire logic crc16_fail,
    input wire logic token_ok,
    input wire logic pid_valid,
    input wire logic [3:0] pid_in,
    input wire logic [3:0] token_ep,
    input wire logic sof_seen,
    input wire logic [1:0] line_state,
    input wire logic suspended,
    // Flags, ports and PHY pins.
    output logic [6:0] signal_flag_vector,
    output logic flag_out_port_a,
    output logic flag_out_port_b,
    output logic flag_out_port_c,
    output logic [4:0] rx_ep_out,
    output logic [1:0] ls_filtered,
    output logic line_port_low_pd_en,
    output logic line_port_high_pd_en,
    output logic [2:0] phy_config_pins,
    output logic resume_out,
    output logic [31:0] otg_flag_mask_out,
    output logic [8:0] power_signal_out
);
    import uifr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////////
    logic [1:0] ls_sync;
    logic [3:0] pins_sync;

    // Stored fields only.
    logic [6:0] sticky_ff;
    logic [23:0] port_masks_ff;
    logic [10:0] sof_ff;
    logic [3:0] pid_ff;
    logic [3:0] ep_ff;
    logic ep_valid_ff;
    logic [15:0] ep_match_ff;
    logic [31:0] otg_mask_ff;
    logic [8:0] power_ff;
    logic pd_dis_ff;
    logic se0_resume_ff;
    logic k_resume_ff;
    logic [3:0] filt_ff;
    logic susp_ctrl_ff;
    logic [2:0] conf_ff;

    // Internal state.
    logic soft_rst_ff;
    logic [6:0] flags_ff;
    logic [6:0] flag_src;
    logic [1:0] ls_prev_ff;

    // Write strobes and resume event.
    logic wr_sticky, wr_ports, wr_sof, wr_epm, wr_otg, wr_pwr, wr_phy;
    logic auto_resume;

    // Line state and PHY-side status arrive from the PHY pins, so they are synchronised.
    // Bits may settle a cycle apart.
    uifr_sync #(.W(6)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .d({line_state, rx_active, rx_error, suspended, crc16_fail}),
        .q({ls_sync, pins_sync})
    );

    // Filtered line state that the flags and resume logic use; no register reads it.
    // Line flags lag by the filter delay.
    uifr_ls_filter u_filt (
        .clk(clk),
        .nrst(nrst),
        .soft_rst(soft_rst_ff),
        .log2_delay(filt_ff),
        .ls_in(ls_sync),
        .ls_out(ls_filtered)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Write strobes per register.
    assign wr_sticky = reg_wr && reg_addr == OFS_STICKY;
    assign wr_ports = reg_wr && reg_addr == OFS_PORT_MASKS;
    assign wr_sof = reg_wr && reg_addr == OFS_SOF;
    assign wr_epm = reg_wr && reg_addr == OFS_EP_MATCH;
    assign wr_otg = reg_wr && reg_addr == OFS_OTG_MASK;
    assign wr_pwr = reg_wr && reg_addr == OFS_POWER;
    assign wr_phy = reg_wr && reg_addr == OFS_PHY_CTRL;

    // Any write to the reset register yields a one-cycle manager reset pulse.
    // PHY fields other than the resume cause bits survive it, so pins hold.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            soft_rst_ff <= 1'b0;
        end else begin
            soft_rst_ff <= reg_wr && reg_addr == OFS_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Live sources of the seven signal flags.
    // Line flags read the filtered state.
    always_comb begin
        flag_src = '0;
        flag_src[FLAG_TOKEN_OK] = token_ok;
        flag_src[FLAG_SE0] = ls_filtered == LS_SE0;
        flag_src[FLAG_K] = ls_filtered == LS_K;
        flag_src[FLAG_J] = ls_filtered == LS_J;
        flag_src[FLAG_CRC16] = pins_sync[0];
        flag_src[FLAG_RXACTIVE] = pins_sync[3];
        flag_src[FLAG_RXERROR] = pins_sync[2];
    end

    // Per flag: sticky bits hold until a one is written, others track or clear per packet.
    // A set beats a same-cycle clear.
    // Error and token flags latch until pkt_start.
    generate
        for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    flags_ff[i] <= 1'b0;
                end else if (soft_rst_ff) begin
                    flags_ff[i] <= 1'b0;
                end else if (sticky_ff[i]) begin
                    if (flag_src[i]) begin
                        flags_ff[i] <= 1'b1;
                    end else if (wr_sticky && reg_wdata[i]) begin
                        flags_ff[i] <= 1'b0;
                    end
                end else if (pkt_start) begin
                    flags_ff[i] <= flag_src[i];
                end else if (flag_src[i]) begin
                    flags_ff[i] <= 1'b1;
                end else if (i == FLAG_RXACTIVE || (i >= FLAG_J && i <= FLAG_SE0)) begin
                    flags_ff[i] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Plain configuration registers.
    // A write in the reset pulse cycle is lost.
    // PHY fields are kept over a manager reset, except the resume cause bits, which clear.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sticky_ff <= '0;
            port_masks_ff <= '0;
            ep_match_ff <= '0;
            otg_mask_ff <= RST_ZERO;
            power_ff <= '0;
            pd_dis_ff <= 1'b0;
            filt_ff <= '0;
            susp_ctrl_ff <= 1'b0;
            conf_ff <= '0;
        end else if (soft_rst_ff) begin
            sticky_ff <= '0;
            port_masks_ff <= '0;
            ep_match_ff <= '0;
            otg_mask_ff <= RST_ZERO;
            power_ff <= '0;
        end else begin
            if (wr_sticky) begin
                sticky_ff <= reg_wdata[6:0];
            end
            if (wr_ports) begin
                port_masks_ff <= reg_wdata[23:0];
            end
            if (wr_epm) begin
                ep_match_ff <= reg_wdata[15:0];
            end
            if (wr_otg) begin
                otg_mask_ff <= reg_wdata;
            end
            if (wr_pwr) begin
                power_ff <= reg_wdata[8:0];
            end
            if (wr_phy) begin
                pd_dis_ff <= reg_wdata[PHY_PD_DIS_BIT];
                filt_ff <= reg_wdata[PHY_FILT_MSB:PHY_FILT_LSB];
                susp_ctrl_ff <= reg_wdata[PHY_SUSP_BIT];
                conf_ff <= reg_wdata[PHY_CONF_MSB:PHY_CONF_LSB];
            end
        end
    end

    // Start-of-frame counter: software load wins, else counts each frame start.
    // Wraps from 0x7FF back to zero.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sof_ff <= '0;
        end else if (soft_rst_ff) begin
            sof_ff <= '0;
        end else if (wr_sof) begin
            sof_ff <= reg_wdata[10:0];
        end else if (sof_seen) begin
            sof_ff <= sof_ff + 11'h1;
        end
    end

    // Captures of the last packet identifier and token endpoint.
    // Valid stays set after the first token.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pid_ff <= '0;
            ep_ff <= '0;
            ep_valid_ff <= 1'b0;
        end else if (soft_rst_ff) begin
            pid_ff <= '0;
            ep_ff <= '0;
            ep_valid_ff <= 1'b0;
        end else begin
            if (pid_valid) begin
                pid_ff <= pid_in;
            end
            if (token_ok) begin
                ep_ff <= token_ep;
                ep_valid_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Auto-resume happens when suspended, enabled, and the filtered line leaves J.
    // Only leaving J counts, so it fires once.
    assign auto_resume = susp_ctrl_ff && pins_sync[1] && ls_prev_ff == LS_J && ls_filtered != LS_J;

    // Resume cause flags: hardware set wins over a software zero write.
    // The resume_out pulse comes once per auto-resume.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            se0_resume_ff <= 1'b0;
            k_resume_ff <= 1'b0;
            ls_prev_ff <= LS_J;
            resume_out <= 1'b0;
        end else if (soft_rst_ff) begin
            se0_resume_ff <= 1'b0;
            k_resume_ff <= 1'b0;
            ls_prev_ff <= LS_J;
            resume_out <= 1'b0;
        end else begin
            ls_prev_ff <= ls_filtered;
            resume_out <= auto_resume;
            if (auto_resume && ls_filtered == LS_SE0) begin
                se0_resume_ff <= 1'b1;
            end else if (wr_phy && !reg_wdata[PHY_SE0_RES_BIT]) begin
                se0_resume_ff <= 1'b0;
            end
            if (auto_resume && ls_filtered == LS_K) begin
                k_resume_ff <= 1'b1;
            end else if (wr_phy && !reg_wdata[PHY_K_RES_BIT]) begin
                k_resume_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Registered outputs: port routing, endpoint delivery and PHY pins.
    // Mask bit 7 of each byte has no flag.
    // Pulldowns on unless the disable bit is set.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag_out_port_a <= 1'b0;
            flag_out_port_b <= 1'b0;
            flag_out_port_c <= 1'b0;
            rx_ep_out <= '0;
            line_port_low_pd_en <= 1'b1;
            line_port_high_pd_en <= 1'b1;
            phy_config_pins <= '0;
            signal_flag_vector <= '0;
            otg_flag_mask_out <= RST_ZERO;
            power_signal_out <= '0;
        end else begin
            flag_out_port_a <= |(flags_ff & port_masks_ff[PORT_A_LSB +: 7]);
            flag_out_port_b <= |(flags_ff & port_masks_ff[PORT_B_LSB +: 7]);
            flag_out_port_c <= |(flags_ff & port_masks_ff[PORT_C_LSB +: 7]);
            rx_ep_out <= {ep_match_ff[ep_ff], ep_ff};
            line_port_low_pd_en <= !pd_dis_ff;
            line_port_high_pd_en <= !pd_dis_ff;
            phy_config_pins <= conf_ff;
            signal_flag_vector <= flags_ff;
            otg_flag_mask_out <= otg_mask_ff;
            power_signal_out <= power_ff;
        end
    end

    // Read data, registered one cycle after reg_rd; reserved bits and unknown offsets read zero.
    // Data holds until the next read.
    // Lower offsets belong elsewhere and read zero.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_STICKY: reg_rdata <= {25'h0, sticky_ff};
                OFS_PORT_MASKS: reg_rdata <= {8'h0, port_masks_ff};
                OFS_SOF: reg_rdata <= {21'h0, sof_ff};
                OFS_PID: reg_rdata <= {28'h0, pid_ff};
                OFS_ENDPOINT: reg_rdata <= {27'h0, ep_valid_ff, ep_ff};
                OFS_EP_MATCH: reg_rdata <= {16'h0, ep_match_ff};
                OFS_OTG_MASK: reg_rdata <= otg_mask_ff;
                OFS_POWER: reg_rdata <= {23'h0, power_ff};
                OFS_PHY_CTRL: reg_rdata <= {13'h0, pd_dis_ff, 4'h0, se0_resume_ff, k_resume_ff,
                    filt_ff, susp_ctrl_ff, conf_ff, 4'h0};
                default: reg_rdata <= '0;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> uifr_regs_props.sv
// Concurrent checks on the ports of the flag and event register block.
`timescale 1ns/1ps
`default_nettype none
module uifr_regs_props
    import uifr_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic line_port_low_pd_en,
    input wire logic line_port_high_pd_en,
    input wire logic [2:0] phy_config_pins,
    input wire logic [31:0] otg_flag_mask_out,
    input wire logic [8:0] power_signal_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////
    // Write and read requests that the checks start from.
    sequence s_phy_wr;
        reg_wr && reg_addr == OFS_PHY_CTRL;
    endsequence
    sequence s_rst_wr;
        reg_wr && reg_addr == OFS_RESET;
    endsequence
    sequence s_rd(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_cfg_pins_follow: assert property (s_phy_wr |=> ##1
        phy_config_pins == $past(reg_wdata[6:4], 2))
        else $error("config pins differ from written field");
    a_pd_dis_follow: assert property (s_phy_wr |=> ##1
        line_port_low_pd_en == !$past(reg_wdata[18], 2))
        else $error("pulldown enable differs from written bit");
    a_pd_both_equal: assert property (line_port_low_pd_en == line_port_high_pd_en)
        else $error("pulldown enables disagree");
    a_unmapped_reads_zero: assert property (reg_rd && reg_addr > OFS_PHY_CTRL
        |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_pid_rsvd_zero: assert property (s_rd(OFS_PID) |=> reg_rdata[31:4] == 28'h0)
        else $error("identifier reserved bits set");
    a_ep_rsvd_zero: assert property (s_rd(OFS_ENDPOINT) |=> reg_rdata[31:5] == 27'h0)
        else $error("endpoint reserved bits set");
    a_sof_rsvd_zero: assert property (s_rd(OFS_SOF) |=> reg_rdata[31:11] == 21'h0)
        else $error("frame counter reserved bits set");
    a_otg_stored: assert property (reg_wr && reg_addr == OFS_OTG_MASK |=> ##1
        otg_flag_mask_out == $past(reg_wdata, 2))
        else $error("otg mask not stored");
    a_pwr_stored: assert property (reg_wr && reg_addr == OFS_POWER |=> ##1
        power_signal_out == $past(reg_wdata[8:0], 2))
        else $error("power field not stored");
    a_soft_rst_clears: assert property (s_rst_wr |=> ##2
        otg_flag_mask_out == 32'h0 && power_signal_out == 9'h0)
        else $error("soft reset left state");
    a_rdata_holds: assert property (!reg_rd && !reg_wr |=> $stable(reg_rdata))
        else $error("read data moved without a read");
endmodule
bind uifr_regs uifr_regs_props u_props (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .line_port_low_pd_en(line_port_low_pd_en), .line_port_high_pd_en(line_port_high_pd_en),
    .phy_config_pins(phy_config_pins), .otg_flag_mask_out(otg_flag_mask_out),
    .power_signal_out(power_signal_out));
`default_nettype wire

// >>> uifr_sync.sv
// Two flip-flop synchroniser for a vector of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module uifr_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    // First stage is only read by the second stage.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= '0;
            q <= '0;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule
`default_nettype wire
